/* File: logic/sbcirq_pkg.sv */
// Shared constants and types of the interrupt and over-temperature block
package sbcirq_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_STATUS_OFS = 8'h00;
  localparam logic [7:0] REG_MASK_OFS   = 8'h04;
  localparam logic [7:0] REG_CTRL_OFS   = 8'h08;
  localparam logic [7:0] REG_STATE_OFS  = 8'h0C;
  // Interrupt status bit positions
  localparam int IRQ_W          = 5;
  localparam int IRQ_BUS_WAKE   = 0;
  localparam int IRQ_WAKE1      = 1;
  localparam int IRQ_WAKE2      = 2;
  localparam int IRQ_CYCLIC     = 3;
  localparam int IRQ_OVERTEMP   = 4;
  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_XSTBY_BIT = 2;
  localparam int CTRL_WEN1_BIT  = 3;
  localparam int CTRL_WEN2_BIT  = 4;
  localparam int CTRL_W         = 5;
  // State register fields
  localparam int STATE_MODE_LSB = 0;
  localparam int STATE_PEND_BIT = 2;
  localparam int STATE_CYC_BIT  = 3;
  localparam int STATE_OT_BIT   = 4;
  // Reset values
  localparam logic [IRQ_W-1:0]  MASK_RST = 5'h1F;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [1:0]        MODE_STANDBY = 2'h0;
  localparam logic [1:0]        MODE_SLEEP   = 2'h1;
  // Synchronised pin inputs
  localparam int PIN_W = 5;
  // Chip operating states, Gray along standby-normal-overtemp
  typedef enum logic [1:0] {
    ST_STANDBY  = 2'h0,
    ST_NORMAL   = 2'h1,
    ST_OVERTEMP = 2'h3,
    ST_SLEEP    = 2'h2
  } sbcirq_state_t;
  // Power and safety outputs
  typedef struct packed {
    logic v1_en;
    logic v2_en;
    logic tx_en;
    logic limp_home;
    logic sys_reset_out_n;
  } sbcirq_pwr_t;
  localparam sbcirq_pwr_t PWR_RST = 5'h19;
endpackage

/* File: logic/sbcirq_top.sv */
// Interrupt line, wake latching, cyclic interrupt and over-temperature control
//
// Contract
// R01 - The interrupt pin is open-drain, active low, and only ever pulls low.
// R02 - The interrupt pin is low while any interrupt is pending and released when none is; the code pulls it low only for pending bits not set in mask_q.
// R03 - Writing one to a status bit clears it and writing zero leaves it alone.
// R04 - Clearing the bus wake flag in standby leaves the latched bus wake request pending.
// R05 - The latched bus wake request clears in normal mode with the standby control bit zero.
// R06 - Cyclic interrupts are enabled on watchdog timeout entry in standby or normal with disable low.
// R07 - Each watchdog overflow in timeout mode sets the cyclic interrupt flag; the code sets it only while cyc_en_q is set.
// R08 - Over-temperature is evaluated only in normal or standby mode.
// R09 - Over-temperature enters overtemp mode, pulls reset low and activates limp home.
// R10 - In overtemp mode both regulators are off and the bus transmitter is disabled.
// R11 - When over-temperature clears, overtemp mode is left for standby.
// R12 - With the standby control bit set the transceiver is low power with bus wake armed.
// R13 - An enabled local wake event raises a wake interrupt in standby or normal mode.
// R14 - Each status bit stays set from its event until the host clears it.
`timescale 1ns/1ns
module sbcirq_top
  import sbcirq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              bus_wake_i,
  input  wire logic [1:0]        wake_pin_i,
  input  wire logic              watchdog_disable_in_i,
  input  wire logic              overtemp_i,
  input  wire logic              wdog_timeout_mode_i,
  input  wire logic              wdog_overflow_i,
  output logic                   irq_out_n_o,
  output logic                   irq_out_n_oe_o,
  output logic                   xcvr_lowpower_o,
  output sbcirq_pwr_t            pwr_o
);

  // Elaboration check on the address width
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 4 and 32");
  end

  logic [PIN_W-1:0]  sync1_q;
  logic [PIN_W-1:0]  sync2_q;
  logic [PIN_W-1:0]  sync3_q;
  logic              wr_en;
  logic              rd_setup;
  logic [7:0]        addr8;
  logic              addr_ok;
  logic [IRQ_W-1:0]  status_q;
  logic [IRQ_W-1:0]  status_set;
  logic [IRQ_W-1:0]  status_clr;
  logic [IRQ_W-1:0]  mask_q;
  logic [CTRL_W-1:0] ctrl_q;
  sbcirq_state_t     state_q;
  sbcirq_state_t     state_d;
  logic              bus_pend_q;
  logic              bus_wake_ev;
  logic              cyc_en_q;
  logic              tmo_q;
  logic              active_mode;
  logic              xcvr_standby_ctrl;
  logic              ot_pin;
  logic              wd_disable_pin;
  logic [1:0]        wake_edge;
  logic [1:0]        mode_sel;

  // Pin synchronisers, two flops then an edge-history flop
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        sync3_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= (i == 0) ? bus_wake_i :
                      (i == 1) ? wake_pin_i[0] :
                      (i == 2) ? wake_pin_i[1] :
                      (i == 3) ? watchdog_disable_in_i : overtemp_i;
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
      end
    end
  end

  // Decoded pin views
  assign bus_wake_ev = sync2_q[0] & ~sync3_q[0];
  assign wake_edge   = sync2_q[2:1] ^ sync3_q[2:1];
  assign wd_disable_pin    = sync2_q[3];
  assign ot_pin            = sync2_q[4];
  assign xcvr_standby_ctrl = ctrl_q[CTRL_XSTBY_BIT];
  assign mode_sel    = ctrl_q[CTRL_MODE_LSB +: 2];
  assign active_mode = (state_q == ST_STANDBY) || (state_q == ST_NORMAL);

  // APB decode, zero wait states
  assign addr8    = 8'(paddr_i);
  assign addr_ok  = (ADDR_W > 8) ? (paddr_i >> 8) == '0 : 1'b1;
  assign wr_en    = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign rd_setup = psel_i & ~penable_i;

  // Ready and error answer for the access phase
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= rd_setup;
      pslverr_o <= rd_setup & ~(addr_ok && (addr8 == REG_STATUS_OFS ||
                   addr8 == REG_MASK_OFS || addr8 == REG_CTRL_OFS ||
                   addr8 == REG_STATE_OFS));
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (addr8)
        REG_STATUS_OFS: prdata_o <= 32'(status_q);
        REG_MASK_OFS:   prdata_o <= 32'(mask_q);
        REG_CTRL_OFS:   prdata_o <= 32'(ctrl_q);
        REG_STATE_OFS:  prdata_o <= 32'({ot_pin, cyc_en_q, bus_pend_q, state_q});
        default:        prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Mask and control registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      mask_q <= MASK_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_en && addr8 == REG_MASK_OFS) begin
        mask_q <= pwdata_i[IRQ_W-1:0];
      end
      if (state_q == ST_OVERTEMP && !ot_pin) begin
        // R11 standby after cooling
        ctrl_q[CTRL_MODE_LSB +: 2] <= MODE_STANDBY;
      end else if (wr_en && addr8 == REG_CTRL_OFS) begin
        ctrl_q <= pwdata_i[CTRL_W-1:0];
      end
    end
  end

  // Chip mode selection with over-temperature override
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY, ST_NORMAL: begin
        // R08 detector gated by mode
        // R09 enter overtemp
        if (ot_pin) begin
          state_d = ST_OVERTEMP;
        end else if (mode_sel[1]) begin
          state_d = ST_NORMAL;
        end else if (mode_sel == MODE_SLEEP) begin
          state_d = ST_SLEEP;
        end else begin
          state_d = ST_STANDBY;
        end
      end
      ST_SLEEP: begin
        if (mode_sel != MODE_SLEEP || bus_wake_ev || (|wake_edge)) begin
          state_d = ST_STANDBY;
        end
      end
      ST_OVERTEMP: begin
        // R11 leave overtemp
        if (!ot_pin) begin
          state_d = ST_STANDBY;
        end
      end
      default: state_d = ST_STANDBY;
    endcase
  end

  // Chip state register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_q <= ST_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // Latched bus wake request
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      bus_pend_q <= 1'b0;
    end else if (xcvr_standby_ctrl && bus_wake_ev) begin
      // R12 wake armed in low power
      bus_pend_q <= 1'b1;
    end else if (state_q == ST_NORMAL && !xcvr_standby_ctrl) begin
      // R05 cleared in normal mode
      bus_pend_q <= 1'b0;
    end
  end

  // Cyclic interrupt enable follows watchdog timeout entry
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      tmo_q    <= 1'b0;
      cyc_en_q <= 1'b0;
    end else begin
      tmo_q <= wdog_timeout_mode_i;
      if (!wdog_timeout_mode_i) begin
        cyc_en_q <= 1'b0;
      end else if (!tmo_q && active_mode && !wd_disable_pin) begin
        // R06 enable on timeout entry
        cyc_en_q <= 1'b1;
      end
    end
  end

  // Interrupt events
  always_comb begin
    status_set               = '0;
    status_set[IRQ_BUS_WAKE] = xcvr_standby_ctrl & bus_wake_ev &
                               (active_mode | state_q == ST_SLEEP);
    // R13 local wake interrupts
    status_set[IRQ_WAKE1]    = ctrl_q[CTRL_WEN1_BIT] & wake_edge[0] & active_mode;
    status_set[IRQ_WAKE2]    = ctrl_q[CTRL_WEN2_BIT] & wake_edge[1] & active_mode;
    // R07 overflow in timeout mode
    status_set[IRQ_CYCLIC]   = cyc_en_q & wdog_timeout_mode_i & wdog_overflow_i;
    status_set[IRQ_OVERTEMP] = active_mode & ot_pin;
  end

  // R03 write one to clear
  assign status_clr = (wr_en && addr8 == REG_STATUS_OFS) ? pwdata_i[IRQ_W-1:0] : '0;

  // Sticky status, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      status_q <= '0;
    end else begin
      // R14 sticky until cleared
      // R04 flag only, request kept
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  // Open-drain interrupt pin drive
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      irq_out_n_o    <= 1'b0;
      irq_out_n_oe_o <= 1'b0;
    end else begin
      // R01 pull low only
      irq_out_n_o    <= 1'b0;
      // R02 low while pending
      irq_out_n_oe_o <= |(((status_q & ~status_clr) | status_set) & ~mask_q);
    end
  end

  // Power, reset and transceiver outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pwr_o           <= PWR_RST;
      xcvr_lowpower_o <= 1'b0;
    end else begin
      // R09 reset low, limp home on
      // R10 regulators and transmitter off
      pwr_o.sys_reset_out_n <= (state_d != ST_OVERTEMP);
      pwr_o.limp_home       <= (state_d == ST_OVERTEMP) | pwr_o.limp_home & (state_d != ST_NORMAL);
      pwr_o.v1_en           <= (state_d == ST_STANDBY) || (state_d == ST_NORMAL);
      pwr_o.v2_en           <= (state_d == ST_NORMAL) && (mode_sel != 2'h2);
      pwr_o.tx_en           <= (state_d == ST_NORMAL) && !xcvr_standby_ctrl;
      // R12 low power when standby bit set
      xcvr_lowpower_o       <= xcvr_standby_ctrl;
    end
  end

  // Assertions
  sequence s_ot_seen;
    active_mode && ot_pin;
  endsequence

  sequence s_ot_outputs;
    state_q == ST_OVERTEMP && !pwr_o.sys_reset_out_n && pwr_o.limp_home;
  endsequence

  a_irq_pin_low: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    irq_out_n_o == 1'b0) // R01
    else $error("interrupt pin driven high");

  a_irq_pending: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    irq_out_n_oe_o == |(status_q & ~$past(mask_q))) // R02
    else $error("interrupt pin does not follow pending bits");

  a_status_w1c: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    status_clr[IRQ_WAKE1] && !status_set[IRQ_WAKE1] |=> !status_q[IRQ_WAKE1]) // R03
    else $error("write one did not clear status");

  a_clear_keeps_pend: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    status_clr[IRQ_BUS_WAKE] && bus_pend_q && state_q == ST_STANDBY |=> bus_pend_q) // R04
    else $error("bus wake request lost on flag clear");

  a_pend_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    state_q == ST_NORMAL && !xcvr_standby_ctrl |=> !bus_pend_q) // R05
    else $error("bus wake request not cleared in normal mode");

  a_cyc_enable: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    wdog_timeout_mode_i && !tmo_q && active_mode && !wd_disable_pin |=> cyc_en_q) // R06
    else $error("cyclic interrupt not enabled");

  a_cyc_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    cyc_en_q && wdog_timeout_mode_i && wdog_overflow_i |=> status_q[IRQ_CYCLIC]) // R07
    else $error("cyclic flag not set on overflow");

  a_ot_gated: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    state_q == ST_SLEEP |=> state_q != ST_OVERTEMP) // R08
    else $error("overtemp entered outside normal or standby");

  a_ot_entry: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_ot_seen |=> s_ot_outputs) // R09
    else $error("overtemp entry outputs wrong");

  a_ot_power: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    state_q == ST_OVERTEMP |-> !pwr_o.v1_en && !pwr_o.v2_en && !pwr_o.tx_en) // R10
    else $error("supplies on in overtemp");

  a_ot_exit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    state_q == ST_OVERTEMP && !ot_pin |=> state_q == ST_STANDBY && pwr_o.sys_reset_out_n) // R11
    else $error("overtemp exit not to standby");

  a_lowpower: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ##1 xcvr_lowpower_o == $past(xcvr_standby_ctrl)) // R12
    else $error("transceiver low power does not follow standby bit");

  a_local_wake: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ctrl_q[CTRL_WEN1_BIT] && wake_edge[0] && active_mode |=> status_q[IRQ_WAKE1]) // R13
    else $error("local wake interrupt missed");

  a_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    status_q[IRQ_WAKE2] && !status_clr[IRQ_WAKE2] |=> status_q[IRQ_WAKE2]) // R14
    else $error("status bit dropped without clear");

endmodule

/* File: bench/sbcirq_host_mdl.sv */
// Host side model: resolves the open-drain interrupt line seen by the host
`timescale 1ns/1ns
module sbcirq_host_mdl (
  input  wire logic irq_out_n_i,
  input  wire logic irq_out_n_oe_i,
  output logic      irq_line_o
);
  // open drain line
  // Pull-up restores high whenever the device lets go
  assign irq_line_o = irq_out_n_oe_i ? irq_out_n_i : 1'b1;
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench of the interrupt and over-temperature block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import sbcirq_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, bus_wake, wd_dis, ot, wd_to, wd_ov;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  wake;
  logic        pready, pslverr, irq_n, irq_oe, lowpwr, irq_line;
  sbcirq_pwr_t pwr;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [32:0] e, m;
  int          mismatches, cmp_count, seed, p, r;
  sbcirq_top DUT (.core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .bus_wake_i(bus_wake), .wake_pin_i(wake),
    .watchdog_disable_in_i(wd_dis), .overtemp_i(ot), .wdog_timeout_mode_i(wd_to),
    .wdog_overflow_i(wd_ov), .irq_out_n_o(irq_n), .irq_out_n_oe_o(irq_oe),
    .xcvr_lowpower_o(lowpwr), .pwr_o(pwr));
  sbcirq_host_mdl HOST (.irq_out_n_i(irq_n), .irq_out_n_oe_i(irq_oe), .irq_line_o(irq_line));
  // Clock of 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic test_done();
    // Notes never matched by an answer count as failures
    if (exp_q.size() != 0) mismatches++;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer, expected answer noted in the queue
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ex, input logic [32:0] mk);
    int n;
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin mismatches++; test_done(); end
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d}, 33'h1FFFFFFFF);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000, 33'h100000000);
  endtask
  task automatic pin_chk(input logic exp_line);
    cyc(2);
    `CHK("irq_line", exp_line, irq_line)
    if (irq_oe === 1'b1) `CHK("irq_out", 1'b0, irq_n)
  endtask
  // Monitor takes the oldest note at each completed access
  always @(posedge clk) begin
    if (rst_b && psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK("apb_answer", e & m, {pslverr, prdata} & m)
    end
  end
  initial begin
    seed = 59;
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; bus_wake = 1'b0; wake = 2'h0; wd_dis = 1'b0; ot = 1'b0;
    wd_to = 1'b0; wd_ov = 1'b0;
    cyc(16);
    rst_b <= 1'b1;
    // Reset values and an unmapped place
    rd(REG_STATUS_OFS, 32'h00);
    rd(REG_MASK_OFS, 32'h1F);
    rd(REG_CTRL_OFS, 32'h00);
    rd(REG_STATE_OFS, 32'h00);
    apb(1'b0, 8'h10, 32'h0, 33'h100000000, 33'h1FFFFFFFF);
    apb(1'b1, 8'h10, 32'hFFFFFFFF, 33'h100000000, 33'h100000000);
    wr(REG_MASK_OFS, 32'h00);
    pin_chk(1'b1);
    $display("test reset done");
    ot <= 1'b1;
    cyc(6);
    `CHK("pwr", 5'h02, pwr)
    pin_chk(1'b0);
    rd(REG_STATE_OFS, 32'h13);
    rd(REG_STATUS_OFS, 32'h10);
    ot <= 1'b0;
    cyc(6);
    `CHK("pwr", 5'h13, pwr)
    rd(REG_STATE_OFS, 32'h00);
    rd(REG_STATUS_OFS, 32'h10);
    wr(REG_STATUS_OFS, 32'h00);
    rd(REG_STATUS_OFS, 32'h10);
    wr(REG_STATUS_OFS, 32'h10);
    rd(REG_STATUS_OFS, 32'h00);
    pin_chk(1'b1);
    wr(REG_CTRL_OFS, 32'h01);
    ot <= 1'b1;
    cyc(6);
    rd(REG_STATE_OFS, 32'h12);
    ot <= 1'b0;
    wr(REG_CTRL_OFS, 32'h00);
    rd(REG_STATUS_OFS, 32'h00);
    $display("test overtemp done");
    wr(REG_CTRL_OFS, 32'h04);
    cyc(2);
    `CHK("lowpower", 1'b1, lowpwr)
    bus_wake <= 1'b1;
    cyc(6);
    bus_wake <= 1'b0;
    rd(REG_STATUS_OFS, 32'h01);
    rd(REG_STATE_OFS, 32'h04);
    wr(REG_STATUS_OFS, 32'h01);
    rd(REG_STATUS_OFS, 32'h00);
    rd(REG_STATE_OFS, 32'h04);
    wr(REG_CTRL_OFS, 32'h03);
    cyc(2);
    `CHK("pwr", 5'h1D, pwr)
    rd(REG_STATE_OFS, 32'h01);
    `CHK("lowpower", 1'b0, lowpwr)
    $display("test bus wake done");
    // local wake pins in random order
    wr(REG_CTRL_OFS, 32'h1B);
    r = $random(seed) & 1;
    for (int i = 0; i < 2; i++) begin
      p = i ^ r;
      wake[p] <= ~wake[p];
      cyc(6);
      rd(REG_STATUS_OFS, 32'h1 << (p + 1));
      wr(REG_STATUS_OFS, 32'h1 << (p + 1));
    end
    $display("test local wake done");
    wd_to <= 1'b1;
    cyc(2);
    rd(REG_STATE_OFS, 32'h09);
    wd_ov <= 1'b1;
    cyc(1);
    wd_ov <= 1'b0;
    cyc(2);
    rd(REG_STATUS_OFS, 32'h08);
    pin_chk(1'b0);
    wr(REG_MASK_OFS, 32'h08);
    pin_chk(1'b1);
    wr(REG_STATUS_OFS, 32'h08);
    wr(REG_MASK_OFS, 32'h00);
    wd_to <= 1'b0;
    wd_dis <= 1'b1;
    cyc(6);
    wd_to <= 1'b1;
    cyc(2);
    rd(REG_STATE_OFS, 32'h01);
    wd_ov <= 1'b1;
    cyc(1);
    wd_ov <= 1'b0;
    cyc(2);
    rd(REG_STATUS_OFS, 32'h00);
    $display("test cyclic done");
    cyc(2);
    test_done();
  end
endmodule
